/* File: bce_pkg.sv */
/*
  Constants for the branch and call execution unit: opcode fields, widths,
  phase encoding and reset values.
  Assumes a four-phase instruction cycle counted by the execution unit itself.
*/
package bce_pkg;
  localparam int          PC_W        = 21;
  localparam int          TGT_W       = 20;
  localparam logic [7:0]  OP_BOV      = 8'he4;
  localparam logic [7:0]  OP_BZ       = 8'he0;
  localparam logic [6:0]  OP_CALL     = 7'h76;
  localparam logic [3:0]  OP_CALL2    = 4'hf;
  localparam int          FLAG_Z      = 2;
  localparam int          FLAG_OV     = 3;
  localparam logic [20:0] PC_RST      = 21'h000000;
  localparam logic [20:0] PC_STEP     = 21'h000002;
  localparam logic [20:0] CALL_RET    = 21'h000004;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  typedef enum logic [1:0] {
    BCE_Q1 = 2'b00,
    BCE_Q2 = 2'b01,
    BCE_Q3 = 2'b11,
    BCE_Q4 = 2'b10
  } bce_phase_t;
endpackage : bce_pkg

/* File: bce_exec.sv */
/*
  Execution unit for branch on overflow, branch on zero and subroutine call.
  Assumes the fetch unit presents the current word on instr_word (and the
  second call word on next_word) for a whole instruction cycle, and that
  the core follows the phase output; this unit runs its own phase counter.
*/
`timescale 1ns/10ps
module bce_exec
  import bce_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic [15:0]             instr_word,
  input  wire logic [15:0]             next_word,
  input  wire logic [bce_pkg::PC_W-1:0] fetch_address,
  input  wire logic [7:0]              status_in,
  input  wire logic [7:0]              accumulator,
  input  wire logic [7:0]              bank_pointer,
  output logic      [bce_pkg::PC_W-1:0] program_counter,
  output logic                         pc_write,
  output logic      [bce_pkg::PC_W-1:0] stack_top,
  output logic                         stack_push,
  output logic      [7:0]              accumulator_shadow,
  output logic      [7:0]              flags_shadow,
  output logic      [7:0]              bank_pointer_shadow,
  output logic      [1:0]              phase,
  output logic                         idle_cycle
);
  import bce_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  bce_phase_t        q;
  logic              is_bov;
  logic              is_bz;
  logic              is_call;
  logic              take;
  logic [PC_W-1:0]   br_target;
  logic [PC_W-1:0]   call_target;

  function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] pc,
                                                 input logic [7:0] n);
    logic [PC_W-1:0] off;
    off = {{(PC_W-9){n[7]}}, n, 1'b0};
    return pc + off;
  endfunction : rel_target

  assign is_bov      = (instr_word[15:8] == OP_BOV);
  assign is_bz       = (instr_word[15:8] == OP_BZ);
  assign is_call     = (instr_word[15:9] == OP_CALL) &&
                       (next_word[15:12] == OP_CALL2);
  assign take        = (is_bov && status_in[FLAG_OV]) ||
                       (is_bz && status_in[FLAG_Z]);
  assign br_target   = rel_target(fetch_address, instr_word[7:0]);
  assign call_target = {next_word[11:0], instr_word[7:0], 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Phase counter
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      q <= BCE_Q1;
    else
      case (q)
        BCE_Q1:  q <= BCE_Q2;
        BCE_Q2:  q <= BCE_Q3;
        BCE_Q3:  q <= BCE_Q4;
        BCE_Q4:  q <= BCE_Q1;
        default: q <= BCE_Q1;
      endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      phase <= 2'h0;
    else
      phase <= (q == BCE_Q4) ? 2'h0 : phase + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Idle cycle after a taken branch or a call
  logic extra;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      extra <= 1'b0;
    else if (q == BCE_Q4)
      extra <= !extra && (take || is_call);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      idle_cycle <= 1'b0;
    else if (q == BCE_Q4)
      idle_cycle <= !extra && (take || is_call);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack push in the third phase of a call
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stack_push <= 1'b0;
      stack_top  <= PC_RST;
    end
    else
    begin
      stack_push <= 1'b0;
      if (q == BCE_Q2 && !extra && is_call)
      begin
        stack_push <= 1'b1;
        stack_top  <= fetch_address - PC_STEP + CALL_RET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shadow copies
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      accumulator_shadow  <= BYTE_RST;
      flags_shadow        <= BYTE_RST;
      bank_pointer_shadow <= BYTE_RST;
    end
    else if (q == BCE_Q2 && !extra && is_call && instr_word[8])
    begin
      accumulator_shadow  <= accumulator;
      flags_shadow        <= status_in;
      bank_pointer_shadow <= bank_pointer;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter write in the fourth phase
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_write        <= 1'b0;
      program_counter <= PC_RST;
    end
    else
    begin
      pc_write <= 1'b0;
      if (q == BCE_Q3 && !extra)
      begin
        if (is_call)
        begin
          pc_write        <= 1'b1;
          program_counter <= call_target;
        end
        else if (take)
        begin
          pc_write        <= 1'b1;
          program_counter <= br_target;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_pc_after_push: assert property (@(posedge clock) disable iff (!rst_n)
    (pc_write && $past(is_call, 2)) |-> $past(stack_push, 1))
    else $error("Call counter write not preceded by push");
  a_branch_target: assert property (@(posedge clock) disable iff (!rst_n)
    (q == BCE_Q3 && !extra && !is_call && take) |=> (pc_write &&
     program_counter == $past(fetch_address) +
       {{(PC_W-9){$past(instr_word[7])}}, $past(instr_word[7:0]), 1'b0}))
    else $error("Branch target wrong");
  a_nottaken_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    (q == BCE_Q3 && !extra && !is_call && !take) |=> !pc_write)
    else $error("Untaken branch wrote counter");
  a_bov_cond: assert property (@(posedge clock) disable iff (!rst_n)
    (q == BCE_Q3 && !extra && is_bov && !status_in[FLAG_OV]) |=> !pc_write)
    else $error("Overflow branch without flag");
  a_bz_cond: assert property (@(posedge clock) disable iff (!rst_n)
    (q == BCE_Q3 && !extra && is_bz && status_in[FLAG_Z]) |=> pc_write)
    else $error("Zero branch not taken");
  a_call_even: assert property (@(posedge clock) disable iff (!rst_n)
    pc_write |-> !program_counter[0])
    else $error("Odd counter target");
  a_shadow_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (q == BCE_Q2 && !instr_word[8]) |=> $stable(flags_shadow))
    else $error("Shadow changed without save bit");
  a_idle_follows: assert property (@(posedge clock) disable iff (!rst_n)
    pc_write |-> ##1 (idle_cycle && extra)[*4] ##1 !extra)
    else $error("No idle cycle after counter write");
  a_call_range: assert property (@(posedge clock) disable iff (!rst_n)
    (q == BCE_Q3 && !extra && is_call) |=>
      program_counter[TGT_W:1] == {$past(next_word[11:0]), $past(instr_word[7:0])})
    else $error("Call target truncated");
  a_flags_copy: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(stack_push) && $past(instr_word[8]) |-> flags_shadow == $past(status_in))
    else $error("Flags shadow mismatch");
  a_push_return: assert property (@(posedge clock) disable iff (!rst_n)
    stack_push |-> stack_top == $past(fetch_address) + PC_STEP)
    else $error("Return address wrong");
  a_push_single: assert property (@(posedge clock) disable iff (!rst_n)
    stack_push |=> !stack_push)
    else $error("Push pulse longer than one clock");
  a_idle_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    extra |-> (!stack_push && !pc_write))
    else $error("Activity during idle cycle");
  a_shadow_copy: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(stack_push) && $past(instr_word[8]) |->
      (accumulator_shadow == $past(accumulator) &&
       bank_pointer_shadow == $past(bank_pointer)))
    else $error("Accumulator or bank shadow mismatch");
endmodule : bce_exec

/* File: bce_fetch_model.sv */
/*
  Fetch unit and return stack model: logs pushes and counter writes.
  Assumes the execution unit's one-clock push and write pulses.
*/
`timescale 1ns/10ps
module bce_fetch_model
  import bce_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     clear,
  input  wire logic                     stack_push,
  input  wire logic [bce_pkg::PC_W-1:0] stack_top,
  input  wire logic                     pc_write,
  input  wire logic [bce_pkg::PC_W-1:0] program_counter,
  output int                            push_count,
  output int                            write_count,
  output logic      [bce_pkg::PC_W-1:0] top_seen,
  output logic      [bce_pkg::PC_W-1:0] pc_seen,
  output logic                          order_ok
);
  import bce_pkg::*;
  always @(posedge clock)
  begin
    if (clear)
    begin
      push_count  <= 0;
      write_count <= 0;
      order_ok    <= 1'b0;
    end
    else
    begin
      if (stack_push)
      begin
        push_count <= push_count + 1;
        top_seen   <= stack_top;
      end
      if (pc_write)
      begin
        write_count <= write_count + 1;
        pc_seen     <= program_counter;
        order_ok    <= (push_count != 0);
      end
    end
  end
endmodule : bce_fetch_model

/* File: tb.sv */
/*
  Self-checking bench for the branch and call unit.
  Assumes one instruction per eight clocks, aligned to the phase output.
*/
`timescale 1ns/10ps
module tb;
  import bce_pkg::*;
  logic [15:0] instr_word, next_word, w1;
  logic [PC_W-1:0] fetch_address, program_counter, stack_top, top_seen, pc_seen;
  logic [7:0] status_in, accumulator, bank_pointer, acc_sh, flg_sh, bnk_sh;
  logic clock, rst_n, pc_write, stack_push, idle_cycle, clear, order_ok;
  logic [1:0] phase;
  int seed, bad_count, num_checks, cycles, tnum, push_count, write_count, i, r;
  bce_exec u_dut (.clock(clock), .rst_n(rst_n), .instr_word(instr_word),
    .next_word(next_word), .fetch_address(fetch_address), .status_in(status_in),
    .accumulator(accumulator), .bank_pointer(bank_pointer),
    .program_counter(program_counter), .pc_write(pc_write), .stack_top(stack_top),
    .stack_push(stack_push), .accumulator_shadow(acc_sh), .flags_shadow(flg_sh),
    .bank_pointer_shadow(bnk_sh), .phase(phase), .idle_cycle(idle_cycle));
  bce_fetch_model u_far (.clock(clock), .clear(clear), .stack_push(stack_push),
    .stack_top(stack_top), .pc_write(pc_write), .program_counter(program_counter),
    .push_count(push_count), .write_count(write_count), .top_seen(top_seen),
    .pc_seen(pc_seen), .order_ok(order_ok));
  always #50 clock = ~clock;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task run_one(input logic [15:0] a, input logic [15:0] b, input logic [20:0] fa,
               input logic [7:0] st);
    logic tk, cl, sv;
    logic [20:0] ex;
    logic [23:0] old;
    int idle;
    while (phase !== 2'd0) @(negedge clock);
    old = {acc_sh, flg_sh, bnk_sh};
    instr_word = a; next_word = b; fetch_address = fa; status_in = st; clear = 1'b1;
    accumulator = 8'($random(seed)); bank_pointer = 8'($random(seed)); idle = 0;
    tk = (a[15:8] == OP_BOV && st[FLAG_OV]) || (a[15:8] == OP_BZ && st[FLAG_Z]);
    cl = (a[15:9] == OP_CALL) && (b[15:12] == OP_CALL2);
    sv = cl && a[8];
    ex = cl ? {b[11:0], a[7:0], 1'b0} : fa + {{12{a[7]}}, a[7:0], 1'b0};
    for (int k = 0; k < 8; k++)
    begin
      @(negedge clock);
      clear = 1'b0;
      if (idle_cycle === 1'b1) idle++;
    end
    check(write_count, tk || cl);
    check(push_count, cl);
    check(idle, (tk || cl) ? 4 : 0);
    check(phase, 2'd0);
    if (tk || cl) check(pc_seen, ex);
    if (cl) check(top_seen, fa + CALL_RET - PC_STEP);
    if (cl) check(order_ok, 1'b1);
    check({acc_sh, flg_sh, bnk_sh}, sv ? {accumulator, st, bank_pointer} : old);
    tnum++;
    $display("test %0d end", tnum);
  endtask : run_one
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial
  begin
    seed = 32'h0770; clock = 0; rst_n = 0; clear = 1; instr_word = 0; next_word = 0;
    fetch_address = 0; status_in = 0; accumulator = 0; bank_pointer = 0;
    bad_count = 0; num_checks = 0; cycles = 0; tnum = 0;
    repeat (10) @(negedge clock);
    rst_n = 1;
    run_one(16'he47f, 16'h0000, 21'h000100, 8'h08);
    run_one(16'he080, 16'h0000, 21'h000010, 8'h04);
    run_one(16'he401, 16'h0000, 21'h000200, 8'hf7);
    run_one(16'he001, 16'h0000, 21'h000200, 8'hfb);
    run_one(16'hedff, 16'hffff, 21'h1ffffc, 8'h5a);
    run_one(16'hec00, 16'hf000, 21'h000002, 8'ha5);
    run_one(16'hec10, 16'h0123, 21'h000040, 8'h0c);
    for (i = 0; i < 40; i++)
    begin
      r = $random(seed);
      case (r[1:0])
        2'd0: w1 = {OP_BOV, r[15:8]};
        2'd1: w1 = {OP_BZ, r[15:8]};
        2'd2: w1 = {OP_CALL, r[2], r[15:8]};
        default: w1 = {8'h12, r[15:8]};
      endcase
      run_one(w1, {OP_CALL2, r[27:16]}, 21'($random(seed)) & 21'h1ffffe,
              8'($random(seed)));
    end
    close_out();
  end
endmodule : tb
